// file: design/dspr_audio_rate.v
// Audio output sample-rate phase accumulator.
`default_nettype none

module dspr_audio_rate #(
   parameter ACC_WIDTH  = 26,
   parameter INC_WIDTH  = 20,
   parameter STEP_CYCLES = 4
) (
   input  wire                 clk,
   input  wire                 rst_n,
   input  wire [INC_WIDTH-1:0] rate_increment,
   output reg                  sample_tick
);

   // Divider that lets the accumulator step once per STEP_CYCLES clocks.
   reg  [7:0]           step_count;
   // Phase accumulator; one extra bit catches the carry.
   reg  [ACC_WIDTH-1:0] phase;
   wire [ACC_WIDTH:0]   phase_sum;

   assign phase_sum = {1'b0, phase} + {{(ACC_WIDTH+1-INC_WIDTH){1'b0}}, rate_increment};

   // Step the phase and pulse the tick on every carry out of the top bit.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step_count  <= 8'h00;
         phase       <= {ACC_WIDTH{1'b0}};
         sample_tick <= 1'b0;
      end else begin
         sample_tick <= 1'b0;
         if (step_count == STEP_CYCLES - 1) begin
            step_count  <= 8'h00;
            phase       <= phase_sum[ACC_WIDTH-1:0];
            sample_tick <= phase_sum[ACC_WIDTH];
         end else begin
            step_count <= step_count + 8'h01;
         end
      end
   end

endmodule

`default_nettype wire

// file: design/dspr_map.vh
// Register offsets, field positions, reset values and timing counts of the peripheral space.
`ifndef DSPR_MAP_VH
`define DSPR_MAP_VH

// Register offsets on the core data bus.
`define DSPR_AUDIO_RATE_LOW      16'hC013
`define DSPR_AUDIO_RATE_HIGH_PLL 16'hC014
`define DSPR_AUDIO_LEFT_SAMPLE   16'hC015
`define DSPR_AUDIO_RIGHT_SAMPLE  16'hC016
`define DSPR_PIN_DIRECTION       16'hC017
`define DSPR_PIN_INPUT_LEVELS    16'hC018
`define DSPR_PIN_OUTPUT_LEVELS   16'hC019
`define DSPR_IRQ_SOURCE_ENABLE   16'hC01A
`define DSPR_IRQ_GLOBAL_BLOCK    16'hC01B
`define DSPR_IRQ_GLOBAL_UNBLOCK  16'hC01C
`define DSPR_IRQ_NESTING_COUNTER 16'hC01D
`define DSPR_MODULATOR_RATE      16'hC01E
`define DSPR_MODULATOR_SAMPLE    16'hC01F
`define DSPR_WATCHDOG_RELOAD     16'hC020
`define DSPR_WATCHDOG_KICK       16'hC021
`define DSPR_WATCHDOG_DECOY      16'hC022

// Field positions.
`define DSPR_RATE_HIGH_NIBBLE_MSB 3
`define DSPR_MODULATOR_SLEEP_BIT  15
`define DSPR_IRQ_AUDIO_BIT        0
`define DSPR_IRQ_MODULATOR_BIT    3

// Reset values.
`define DSPR_RESET_WORD 16'h0000

// Timing and keys.
`define DSPR_AUDIO_STEP_CYCLES    4
`define DSPR_MODULATOR_CYCLE_MULT 128
`define DSPR_WATCHDOG_PRESCALE    65536
`define DSPR_WATCHDOG_KEY         16'h4EA9

`endif

// file: design/dspr_regspace.v
// Peripheral register space: audio rate, pins, nesting interrupts, modulator, watchdog.
`default_nettype none
`include "dspr_map.vh"

// Overview of operation
// - Every fourth cycle add 20-bit rate increment
// - Accumulator overflow latches samples, raises audio irq
// - Direction bit one drives pin as output
// - Output values kept while pin is input
// - Input register reads pins; port raises no irq
// - Enable register gates eight interrupt sources
// - Enable changes act within six cycles
// - Block write increments nesting counter
// - Unblock write decrements counter, not below zero
// - Interrupts delivered only when counter is zero
// - Taken interrupt increments nesting counter
// - Modulator sample lasts 128 times divider cycles
// - Divider bit fifteen powers converter down
// - Sample register holds latest conversion
// - Key write activates and reloads watchdog
// - Counter decrements per 65536 cycles, underflow resets
// - Running watchdog cannot stop, reload frozen
// - Reload or decoy access while running voids next kick
// - Wrong key voids the following kick
// - Watchdog register reads return undefined
module dspr_regspace #(
   parameter WDOG_PRESCALE = `DSPR_WATCHDOG_PRESCALE,
   parameter MOD_MULT      = `DSPR_MODULATOR_CYCLE_MULT,
   parameter PIN_COUNT     = 4
) (
   input  wire                 clk,
   input  wire                 rst_n,
   input  wire [15:0]          bus_addr,
   input  wire                 bus_wr,
   input  wire                 bus_rd,
   input  wire [15:0]          bus_wdata,
   output reg  [15:0]          bus_rdata,
   input  wire [PIN_COUNT-1:0] pin_in,
   output reg  [PIN_COUNT-1:0] pin_out,
   output reg  [PIN_COUNT-1:0] pin_oe,
   output reg  [15:0]          audio_left_out,
   output reg  [15:0]          audio_right_out,
   output reg                  audio_out_strobe,
   input  wire [15:0]          modulator_result,
   output reg                  modulator_sleep,
   output reg                  modulator_sample_strobe,
   input  wire [7:0]           irq_source_event,
   input  wire                 irq_ack,
   output reg                  irq_request,
   output reg  [2:0]           irq_index,
   output reg                  watchdog_core_reset,
   output reg                  watchdog_active
);

   // Software-visible registers.
   reg  [15:0] audio_rate_low;         // Low sixteen bits of the rate increment.
   reg  [15:0] audio_rate_high_pll;    // Top nibble of the increment plus clock control.
   reg  [15:0] audio_left_sample;      // Next left sample for output.
   reg  [15:0] audio_right_sample;     // Next right sample for output.
   reg  [3:0]  pin_direction;          // One marks an output pin.
   reg  [3:0]  pin_output_levels;      // Levels driven on output pins.
   reg  [7:0]  irq_source_enable;      // Per-source gate.
   reg  [4:0]  irq_nesting_counter;    // Zero means interrupts may be delivered.
   reg  [15:0] modulator_rate_setting; // Sleep bit and cycle factor.
   reg  [15:0] modulator_sample;       // Latest conversion result.

   // Internal state.
   reg  [7:0]  irq_pending;            // Sticky events waiting for delivery.
   reg  [7:0]  enable_pipe;            // Enable as seen by the delivery logic.
   reg  [21:0] modulator_count;        // Cycle count within one conversion.
   reg  [3:0]  pin_sample;             // Registered pin levels for reads.

   // Decoded write and read strobes.
   wire        wr_rate_low;
   wire        wr_rate_high;
   wire        wr_left;
   wire        wr_right;
   wire        wr_direction;
   wire        wr_out_levels;
   wire        wr_enable;
   wire        wr_block;
   wire        wr_unblock;
   wire        wr_counter;
   wire        wr_mod_rate;
   wire        wr_mod_sample;
   wire        wr_wdog_reload;
   wire        wr_wdog_kick;
   wire        wdog_guard_access;

   // Sub-block results.
   wire        audio_tick;
   wire        watchdog_kick_pulse;
   wire        wdog_running;

   // Modulator helpers.
   wire [14:0] modulator_cycle_factor;
   wire [21:0] modulator_period;
   wire        modulator_tick;

   // Interrupt delivery helpers.
   wire [7:0]  irq_new_events;
   wire [7:0]  irq_deliverable;
   reg  [2:0]  next_irq_index;
   reg         next_irq_request;
   reg  [4:0]  next_counter;
   reg  [7:0]  next_pending;
   integer     i;

   // True when the bus writes the given offset.
   function is_write;
      input [15:0] addr;
      input [15:0] target;
      input        wr;
      begin
         is_write = wr && (addr == target);
      end
   endfunction

   // Five-bit counter step with saturation at both ends.
   function [4:0] nest_step;
      input [4:0] value;
      input       up;
      input       down;
      begin
         if (up && !down) begin
            nest_step = (value == 5'h1F) ? 5'h1F : value + 5'h01;
         end else if (down && !up) begin
            nest_step = (value == 5'h00) ? 5'h00 : value - 5'h01;
         end else begin
            nest_step = value;
         end
      end
   endfunction

   assign wr_rate_low    = is_write(bus_addr, `DSPR_AUDIO_RATE_LOW, bus_wr);
   assign wr_rate_high   = is_write(bus_addr, `DSPR_AUDIO_RATE_HIGH_PLL, bus_wr);
   assign wr_left        = is_write(bus_addr, `DSPR_AUDIO_LEFT_SAMPLE, bus_wr);
   assign wr_right       = is_write(bus_addr, `DSPR_AUDIO_RIGHT_SAMPLE, bus_wr);
   assign wr_direction   = is_write(bus_addr, `DSPR_PIN_DIRECTION, bus_wr);
   assign wr_out_levels  = is_write(bus_addr, `DSPR_PIN_OUTPUT_LEVELS, bus_wr);
   assign wr_enable      = is_write(bus_addr, `DSPR_IRQ_SOURCE_ENABLE, bus_wr);
   assign wr_block       = is_write(bus_addr, `DSPR_IRQ_GLOBAL_BLOCK, bus_wr);
   assign wr_unblock     = is_write(bus_addr, `DSPR_IRQ_GLOBAL_UNBLOCK, bus_wr);
   assign wr_counter     = is_write(bus_addr, `DSPR_IRQ_NESTING_COUNTER, bus_wr);
   assign wr_mod_rate    = is_write(bus_addr, `DSPR_MODULATOR_RATE, bus_wr);
   assign wr_mod_sample  = is_write(bus_addr, `DSPR_MODULATOR_SAMPLE, bus_wr);
   assign wr_wdog_reload = is_write(bus_addr, `DSPR_WATCHDOG_RELOAD, bus_wr);
   assign wr_wdog_kick   = is_write(bus_addr, `DSPR_WATCHDOG_KICK, bus_wr);

   // Any touch of the reload or decoy register counts, reads included.
   assign wdog_guard_access = (bus_wr || bus_rd) &&
                              ((bus_addr == `DSPR_WATCHDOG_RELOAD) ||
                               (bus_addr == `DSPR_WATCHDOG_DECOY));

   dspr_audio_rate #(
      .ACC_WIDTH   (26),
      .INC_WIDTH   (20),
      .STEP_CYCLES (`DSPR_AUDIO_STEP_CYCLES)
   ) u_audio_rate (
      .clk            (clk),
      .rst_n          (rst_n),
      .rate_increment ({audio_rate_high_pll[`DSPR_RATE_HIGH_NIBBLE_MSB:0], audio_rate_low}),
      .sample_tick    (audio_tick)
   );

   // Keyed watchdog; it owns its own reload copy and countdown.
   dspr_watchdog #(
      .PRESCALE (WDOG_PRESCALE)
   ) u_watchdog (
      .clk          (clk),
      .rst_n        (rst_n),
      .reload_wr    (wr_wdog_reload),
      .wdata        (bus_wdata),
      .kick_wr      (wr_wdog_kick),
      .guard_access (wdog_guard_access),
      .active       (wdog_running),
      .core_reset   (watchdog_kick_pulse)
   );

   // Plain read-write storage and the audio output latch.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         audio_rate_low      <= `DSPR_RESET_WORD;
         audio_rate_high_pll <= `DSPR_RESET_WORD;
         audio_left_sample   <= `DSPR_RESET_WORD;
         audio_right_sample  <= `DSPR_RESET_WORD;
         audio_left_out      <= `DSPR_RESET_WORD;
         audio_right_out     <= `DSPR_RESET_WORD;
         audio_out_strobe    <= 1'b0;
         irq_source_enable   <= 8'h00;
      end else begin
         if (wr_rate_low) begin
            audio_rate_low <= bus_wdata;
         end
         if (wr_rate_high) begin
            audio_rate_high_pll <= bus_wdata;
         end
         if (wr_left) begin
            audio_left_sample <= bus_wdata;
         end
         if (wr_right) begin
            audio_right_sample <= bus_wdata;
         end
         if (wr_enable) begin
            irq_source_enable <= bus_wdata[7:0];
         end
         audio_out_strobe <= audio_tick;
         if (audio_tick) begin
            audio_left_out  <= audio_left_sample;
            audio_right_out <= audio_right_sample;
         end
      end
   end

   // General purpose pins; output levels survive while a pin is an input.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_direction     <= 4'h0;
         pin_output_levels <= 4'h0;
         pin_out           <= 4'h0;
         pin_oe            <= 4'h0;
         pin_sample        <= 4'h0;
      end else begin
         if (wr_direction) begin
            pin_direction <= bus_wdata[3:0];
         end
         if (wr_out_levels) begin
            pin_output_levels <= bus_wdata[3:0];
         end
         pin_oe     <= wr_direction ? bus_wdata[3:0] : pin_direction;
         pin_out    <= wr_out_levels ? bus_wdata[3:0] : pin_output_levels;
         pin_sample <= pin_in;
      end
   end

   // Modulator timing: a zero factor or the sleep bit stops conversions.
   assign modulator_cycle_factor = modulator_rate_setting[14:0];
   assign modulator_period = {modulator_cycle_factor, 7'h00};
   assign modulator_tick = !modulator_rate_setting[`DSPR_MODULATOR_SLEEP_BIT] &&
                           (modulator_cycle_factor != 15'h0000) &&
                           (modulator_count >= modulator_period - 22'h000001);

   // Divider, sleep control and sample capture of the input modulator.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         modulator_rate_setting  <= `DSPR_RESET_WORD;
         modulator_sample        <= `DSPR_RESET_WORD;
         modulator_count         <= 22'h000000;
         modulator_sleep         <= 1'b0;
         modulator_sample_strobe <= 1'b0;
      end else begin
         if (wr_mod_rate) begin
            modulator_rate_setting <= bus_wdata;
         end
         modulator_sleep <= modulator_rate_setting[`DSPR_MODULATOR_SLEEP_BIT];
         modulator_sample_strobe <= modulator_tick;
         if (modulator_rate_setting[`DSPR_MODULATOR_SLEEP_BIT] || modulator_tick) begin
            modulator_count <= 22'h000000;
         end else begin
            modulator_count <= modulator_count + 22'h000001;
         end
         if (modulator_tick) begin
            modulator_sample <= modulator_result;
         end else if (wr_mod_sample) begin
            modulator_sample <= bus_wdata;
         end
      end
   end

   // Events from this block join those from the rest of the chip.
   assign irq_new_events = irq_source_event
                         | {4'h0, modulator_tick, 2'b00, audio_tick};
   // gated by enable and zero count
   assign irq_deliverable = irq_pending & enable_pipe &
                            {8{irq_nesting_counter == 5'h00}};

   // Next state of the nesting counter, pending set and request.
   always @* begin
      next_pending     = irq_pending;
      next_irq_request = 1'b0;
      next_irq_index   = irq_index;
      // Lowest source number has the highest priority.
      for (i = 7; i >= 0; i = i - 1) begin
         if (irq_deliverable[i]) begin
            next_irq_request = 1'b1;
            next_irq_index   = i[2:0];
         end
      end
      if (irq_ack && irq_request) begin
         next_pending[irq_index] = 1'b0;
         next_irq_request = 1'b0;
      end
      // New events win over the clear in the same cycle.
      next_pending = next_pending | irq_new_events;
      if (wr_counter) begin
         next_counter = bus_wdata[4:0];
      end else begin
         next_counter = nest_step(nest_step(irq_nesting_counter, wr_block, wr_unblock),
                                  irq_ack && irq_request, 1'b0);
      end
   end

   // Interrupt controller state; the enable passes one stage before use.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_pending         <= 8'h00;
         enable_pipe         <= 8'h00;
         irq_nesting_counter <= 5'h00;
         irq_request         <= 1'b0;
         irq_index           <= 3'h0;
      end else begin
         irq_pending         <= next_pending;
         enable_pipe         <= irq_source_enable;
         irq_nesting_counter <= next_counter;
         irq_request         <= next_irq_request;
         irq_index           <= next_irq_index;
      end
   end

   // Registered read data; write-only and unmapped offsets read as zero.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_rdata           <= `DSPR_RESET_WORD;
         watchdog_core_reset <= 1'b0;
         watchdog_active     <= 1'b0;
      end else begin
         watchdog_core_reset <= watchdog_kick_pulse;
         watchdog_active     <= wdog_running;
         if (bus_rd) begin
            case (bus_addr)
               `DSPR_AUDIO_RATE_LOW: begin
                  bus_rdata <= audio_rate_low;
               end
               `DSPR_AUDIO_RATE_HIGH_PLL: begin
                  bus_rdata <= audio_rate_high_pll;
               end
               `DSPR_AUDIO_LEFT_SAMPLE: begin
                  bus_rdata <= audio_left_sample;
               end
               `DSPR_AUDIO_RIGHT_SAMPLE: begin
                  bus_rdata <= audio_right_sample;
               end
               `DSPR_PIN_DIRECTION: begin
                  bus_rdata <= {12'h000, pin_direction};
               end
               `DSPR_PIN_INPUT_LEVELS: begin
                  bus_rdata <= {12'h000, pin_sample};
               end
               `DSPR_PIN_OUTPUT_LEVELS: begin
                  bus_rdata <= {12'h000, pin_output_levels};
               end
               `DSPR_IRQ_SOURCE_ENABLE: begin
                  bus_rdata <= {8'h00, irq_source_enable};
               end
               `DSPR_IRQ_NESTING_COUNTER: begin
                  bus_rdata <= {11'h000, irq_nesting_counter};
               end
               `DSPR_MODULATOR_RATE: begin
                  bus_rdata <= modulator_rate_setting;
               end
               `DSPR_MODULATOR_SAMPLE: begin
                  bus_rdata <= modulator_sample;
               end
               default: begin
                  bus_rdata <= `DSPR_RESET_WORD;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// file: design/dspr_watchdog.v
// Keyed watchdog that asks for a core reset when its counter underflows.
`default_nettype none
`include "dspr_map.vh"

module dspr_watchdog #(
   parameter PRESCALE = `DSPR_WATCHDOG_PRESCALE
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        reload_wr,
   input  wire [15:0] wdata,
   input  wire        kick_wr,
   input  wire        guard_access,
   output reg         active,
   output reg         core_reset
);

   reg [15:0] reload_value;   // Reload in use; frozen once running.
   reg [15:0] count;          // Main watchdog counter.
   reg [31:0] prescale;       // Cycle divider for the counter.
   reg        skip_next_kick; // Set when the next kick must be ignored.

   // Kick, reload and countdown logic.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reload_value   <= `DSPR_RESET_WORD;
         count          <= `DSPR_RESET_WORD;
         prescale       <= 32'h00000000;
         skip_next_kick <= 1'b0;
         active         <= 1'b0;
         core_reset     <= 1'b0;
      end else begin
         core_reset <= 1'b0;
         if (reload_wr && !active) begin
            reload_value <= wdata;
         end
         if (kick_wr) begin
            if (skip_next_kick) begin
               skip_next_kick <= (wdata != `DSPR_WATCHDOG_KEY);
            end else if (wdata == `DSPR_WATCHDOG_KEY) begin
               active   <= 1'b1;
               count    <= reload_value;
               prescale <= 32'h00000000;
            end else begin
               skip_next_kick <= 1'b1;
            end
         end else if (guard_access && active) begin
            skip_next_kick <= 1'b1;
         end
         if (active && !(kick_wr && !skip_next_kick && wdata == `DSPR_WATCHDOG_KEY)) begin
            if (prescale == PRESCALE - 1) begin
               prescale <= 32'h00000000;
               if (count == 16'h0000) begin
                  core_reset <= 1'b1;
                  count      <= reload_value;
               end else begin
                  count <= count - 16'h0001;
               end
            end else begin
               prescale <= prescale + 32'h00000001;
            end
         end
      end
   end

endmodule

`default_nettype wire

// file: testbench/dspr_core_model.sv
// Core side model that takes interrupt requests after a chosen lag.
`default_nettype none
module dspr_core_model (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       irq_request,
   input wire logic [1:0] lag,
   output var logic       irq_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_n; // Cycles the request has waited.
   // Acknowledge for one cycle once the lag has run out.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ack <= 1'b0;
         wait_n <= 2'h0;
      end else if (irq_ack) begin
         irq_ack <= 1'b0;
         wait_n <= 2'h0;
      end else if (irq_request) begin
         if (wait_n == lag) irq_ack <= 1'b1;
         else wait_n <= wait_n + 2'h1;
      end
   end
endmodule
`default_nettype wire

// file: testbench/dspr_regspace_sva.sv
// Port-level checks on the peripheral register space.
`default_nettype none
module dspr_regspace_sva (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [15:0] bus_addr,
   input wire logic        bus_wr,
   input wire logic [15:0] bus_wdata,
   input wire logic [3:0]  pin_oe,
   input wire logic        audio_out_strobe,
   input wire logic        modulator_sleep,
   input wire logic        modulator_sample_strobe,
   input wire logic        irq_ack,
   input wire logic        irq_request,
   input wire logic        watchdog_core_reset,
   input wire logic        watchdog_active
);
   timeunit 1ns;
   timeprecision 1ps;
   // A write that carries the watchdog key.
   wire kick = bus_wr && bus_addr == 16'hC021 && bus_wdata == 16'h4EA9;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // The largest increment still needs 64 steps to overflow.
   sequence s_quiet;
      !audio_out_strobe [*8];
   endsequence
   sequence s_pulse;
      watchdog_active ##1 !watchdog_core_reset;
   endsequence
   dir_oe_a:
   assert property (bus_wr && bus_addr == 16'hC017 |=> pin_oe == $past(bus_wdata[3:0]))
      else $error("pin enables differ from direction write");
   audio_gap_a:
   assert property (audio_out_strobe |=> s_quiet)
      else $error("audio strobes too close");
   ack_drop_a:
   assert property (irq_ack && irq_request |=> !irq_request)
      else $error("request stays after acknowledge");
   block_hold_a:
   assert property (bus_wr && bus_addr == 16'hC01B |-> ##[1:6] !irq_request)
      else $error("request not held off by block write");
   sleep_quiet_a:
   assert property (modulator_sleep && $past(modulator_sleep) |-> !modulator_sample_strobe)
      else $error("conversion while powered down");
   wdog_stay_a:
   assert property (watchdog_active |=> watchdog_active)
      else $error("watchdog stopped");
   wdog_start_a:
   assert property (!watchdog_active && !kick |=> !watchdog_active || $past(kick, 2))
      else $error("watchdog started without key");
   wdog_pulse_a:
   assert property (watchdog_core_reset |-> s_pulse)
      else $error("core reset not a pulse of a running watchdog");
endmodule
`default_nettype wire

// file: testbench/test_dsp_peripheral_register_space.sv
// Self-checking bench for the peripheral register space.
`default_nettype none
module test_dsp_peripheral_register_space;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, bus_wr = 0, bus_rd = 0, rd_d = 0, irq_ack, irq_request;
   logic [15:0] bus_addr = 0, bus_wdata = 0, modulator_result = 0, bus_rdata, v, al, ar;
   logic [15:0] audio_left_out, audio_right_out;
   logic [3:0] pin_in = 0, pin_out, pin_oe;
   logic [7:0] irq_source_event = 0;
   logic [2:0] irq_index;
   logic [1:0] lag = 0;
   logic audio_out_strobe, modulator_sleep, modulator_sample_strobe;
   logic watchdog_core_reset, watchdog_active;
   logic [31:0] seed = 32'hAF645288;
   logic [15:0] q[$]; // Expected read words, oldest first.
   logic [15:0] adr[8] = '{16'hC013, 16'hC014, 16'hC015, 16'hC016,
                           16'hC017, 16'hC019, 16'hC01A, 16'hC01D};
   logic [15:0] msk[8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
                           16'h000F, 16'h000F, 16'h00FF, 16'h001F};
   int mismatches = 0, n_tests = 0, cyc = 0, hits = 0, n;
   always #2.5 clk = ~clk;
   dspr_regspace #(.WDOG_PRESCALE(16)) DUT (.*);
   dspr_core_model partner (.*);
   function automatic logic [15:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   task automatic chk(input string nm, input logic [15:0] s, e);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic summarize();
      if (mismatches == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // One bus cycle; a read notes its expected word.
   task automatic acc(input logic w, input logic [15:0] a, d);
      if (!w) q.push_back(d);
      bus_wr <= w;
      bus_rd <= !w;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
      @(posedge clk);
   endtask
   // Service one interrupt; the routine ends with an unblock write.
   task automatic isr(input logic [2:0] b);
      n = 0;
      while (irq_request !== 1'b1 && n < 5) begin
         @(posedge clk);
         n++;
      end
      chk("irq_request", irq_request, 1);
      chk("irq_index", irq_index, b);
      repeat (6) @(posedge clk);
      acc(0, 16'hC01D, 1);
      acc(1, 16'hC01C, 0);
   endtask
   // Count edges until a strobe is seen, giving up at 1100.
   task automatic gap(input logic m, output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while ((m ? modulator_sample_strobe : audio_out_strobe) !== 1'b1 && k < 1100);
   endtask
   // Read compare, watchdog pulse count and hang limit.
   always @(posedge clk) begin
      rd_d <= bus_rd;
      if (watchdog_core_reset === 1'b1) hits++;
      cyc++;
      if (cyc == 8000) begin
         mismatches++;
         summarize();
      end
      if (rd_d && q.size() > 0) chk("bus_rdata", bus_rdata, q.pop_front());
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 13; i++) acc(0, 16'(i) + 16'hC013, 0);
      acc(0, 16'hC030, 0);
      for (int i = 0; i < 8; i++) begin
         v = xs() & msk[i];
         acc(1, adr[i], v);
         acc(0, adr[i], v);
      end
      for (int i = 0; i < 8; i++) if (i < 2 || i > 5) acc(1, adr[i], 0);
      pin_in <= 4'h5;
      acc(1, 16'hC018, 16'h000A);
      acc(0, 16'hC018, 16'h0005);
      acc(1, 16'hC017, 16'h000F);
      acc(1, 16'hC019, 16'h000A);
      acc(1, 16'hC017, 16'h0000);
      acc(1, 16'hC017, 16'h000F);
      chk("pin_out", pin_out, 16'h000A);
      chk("pin_oe", pin_oe, 16'h000F);
      acc(0, 16'hC019, 16'h000A);
      acc(1, 16'hC01A, 16'h00FF);
      repeat (4) begin
         pin_in <= ~pin_in;
         @(posedge clk);
      end
      repeat (4) @(posedge clk);
      chk("irq_request", irq_request, 0);
      for (int b = 0; b < 8; b++) begin
         acc(1, 16'hC01A, 0);
         irq_source_event <= 8'h01 << b;
         @(posedge clk);
         irq_source_event <= 8'h00;
         repeat (8) @(posedge clk);
         chk("irq_request", irq_request, 0);
         v = xs();
         lag <= v[1:0];
         acc(1, 16'hC01A, 16'h0001 << b);
         isr(3'(b));
      end
      acc(1, 16'hC01A, 16'h0004);
      acc(1, 16'hC01B, 16'h1234);
      irq_source_event <= 8'h04;
      @(posedge clk);
      irq_source_event <= 8'h00;
      repeat (10) @(posedge clk);
      chk("irq_request", irq_request, 0);
      acc(1, 16'hC01C, 0);
      isr(2);
      acc(1, 16'hC01C, 0);
      acc(0, 16'hC01D, 0);
      repeat (33) acc(1, 16'hC01B, 0);
      acc(0, 16'hC01D, 16'h001F);
      acc(1, 16'hC01D, 0);
      al = xs();
      ar = xs();
      acc(1, 16'hC015, al);
      acc(1, 16'hC016, ar);
      acc(1, 16'hC014, 16'h0014);
      gap(0, n);
      gap(0, n);
      chk("audio gap", 16'(n), 1024);
      chk("audio_left_out", audio_left_out, al);
      chk("audio_right_out", audio_right_out, ar);
      acc(1, 16'hC01A, 16'h0001);
      isr(0);
      acc(1, 16'hC014, 0);
      v = xs();
      modulator_result <= v;
      acc(1, 16'hC01E, 16'h0004);
      gap(1, n);
      gap(1, n);
      chk("modulator gap", 16'(n), 512);
      acc(0, 16'hC01F, v);
      acc(1, 16'hC01E, 16'h8004);
      repeat (3) @(posedge clk);
      gap(1, n);
      chk("modulator idle", 16'(n), 1100);
      chk("modulator_sleep", modulator_sleep, 1);
      acc(1, 16'hC020, 16'h0002);
      acc(1, 16'hC021, 16'h1111);
      acc(1, 16'hC021, 16'h4EA9);
      repeat (2) @(posedge clk);
      chk("watchdog_active", watchdog_active, 0);
      repeat (4) begin
         acc(1, 16'hC021, 16'h4EA9);
         repeat (26) @(posedge clk);
      end
      chk("watchdog pulses", 16'(hits), 0);
      chk("watchdog_active", watchdog_active, 1);
      acc(1, 16'hC022, 0);
      acc(1, 16'hC021, 16'h4EA9);
      repeat (25) @(posedge clk);
      chk("watchdog pulses", 16'(hits), 1);
      summarize();
   end
endmodule
bind dspr_regspace dspr_regspace_sva u_sva (.*);
`default_nettype wire
